// >>> core/irqcfg_slot.sv
// request detection and routing for one external interrupt source
// assumes a filtered pin level already on pclk
`timescale 1ns/10ps
module irqcfg_slot
    import irqcfg_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       pin_flt,
    input  wire logic [1:0] sense,
    input  wire logic       route,
    input  wire logic [2:0] level,
    output logic            irq_req_q,
    output logic [2:0]      irq_prio_q,
    output logic            xfer_req_q,
    output logic [1:0]      xfer_chan_q,
    output logic            chan_bad_q
);

    logic prev_q;
    logic active_d;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prev_q <= 1'b0;
        else
            prev_q <= pin_flt;
    end

    // active condition decode
    always_comb
    begin
        unique case (sense)
            SENSE_LOW:  active_d = !pin_flt;
            SENSE_HIGH: active_d = pin_flt;
            SENSE_FALL: active_d = prev_q && !pin_flt;
            SENSE_RISE: active_d = !prev_q && pin_flt;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_req_q   <= 1'b0;
            irq_prio_q  <= LEVEL_OFF;
            xfer_req_q  <= 1'b0;
            xfer_chan_q <= 2'h0;
            chan_bad_q  <= 1'b0;
        end
        else
        begin
            irq_req_q   <= active_d && !route && (level != LEVEL_OFF);
            irq_prio_q  <= level;
            xfer_req_q  <= active_d && route && !level[2];
            xfer_chan_q <= level[1:0];
            chan_bad_q  <= route && level[2];
        end
    end

endmodule // irqcfg_slot

// >>> core/irqcfg_top.sv
// configuration register for interrupt slots 8..11 with APB access
// assumes an APB3 master on pclk; the pins are asynchronous to pclk
`timescale 1ns/10ps
module irqcfg_top
    import irqcfg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_irq_pin_a,
    input  wire logic        ext_irq_pin_b,
    output logic [1:0]       irq_req,
    output logic [5:0]       irq_prio,
    output logic [1:0]       xfer_req,
    output logic [3:0]       xfer_chan
);

    logic [31:0]        cfg_q;
    logic [31:0]        prdata_q;
    logic               pready_q;
    logic               pslverr_q;
    logic               access_d;
    logic               done_d;
    logic               hit_cfg_d;
    logic               hit_stat_d;
    logic [31:0]        stat_d;
    logic [NUM_EXT-1:0] pin_raw;
    logic [NUM_EXT-1:0] sync1_q;
    logic [NUM_EXT-1:0] sync2_q;
    logic [NUM_EXT-1:0] sync3_q;
    logic [NUM_EXT-1:0] flt_q;
    logic [NUM_EXT-1:0] chan_bad;
    logic [1:0]         sense   [NUM_EXT];
    logic               route   [NUM_EXT];
    logic [2:0]         level   [NUM_EXT];

    assign pin_raw  = {ext_irq_pin_b, ext_irq_pin_a};
    assign access_d = psel && penable && !pready_q;
    assign done_d   = psel && penable && pready_q;
    assign hit_cfg_d  = (paddr == CFG_ADDR);
    assign hit_stat_d = (paddr == STAT_ADDR);

    // bus answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= access_d;
            pslverr_q <= access_d && !hit_cfg_d && !hit_stat_d;
            if (access_d && !pwrite && hit_cfg_d)
                prdata_q <= cfg_q;
            else if (access_d && !pwrite && hit_stat_d)
                prdata_q <= stat_d;
            else
                prdata_q <= 32'h0000_0000;
        end
    end

    // config store; bits 7:6 of each slot cleared, reserved slots otherwise stored as written, reset to zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cfg_q <= CFG_RESET;
        else if (done_d && pwrite && hit_cfg_d)
            cfg_q <= pwdata & CFG_WR_MASK;
    end

    always_comb
    begin
        stat_d = 32'h0000_0000;
        stat_d[STAT_PIN_LSB +: NUM_EXT] = flt_q;
        stat_d[STAT_BAD_LSB +: NUM_EXT] = chan_bad;
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // pin synchroniser; level accepted once stages two and three agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end
        else
        begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EXT; gi++)
        begin : g_src
            localparam int BASE = (EXT_FIRST + gi) * SLOT_W;

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    flt_q[gi] <= 1'b0;
                else if (sync2_q[gi] == sync3_q[gi])
                    flt_q[gi] <= sync3_q[gi];
            end

            assign sense[gi] = cfg_q[BASE + SENSE_LSB +: 2];
            assign route[gi] = cfg_q[BASE + ROUTE_BIT];
            assign level[gi] = cfg_q[BASE + LEVEL_LSB +: 3];

            irqcfg_slot u_slot
            (
                .pclk        (pclk),
                .presetn     (presetn),
                .pin_flt     (flt_q[gi]),
                .sense       (sense[gi]),
                .route       (route[gi]),
                .level       (level[gi]),
                .irq_req_q   (irq_req[gi]),
                .irq_prio_q  (irq_prio[gi*3 +: 3]),
                .xfer_req_q  (xfer_req[gi]),
                .xfer_chan_q (xfer_chan[gi*2 +: 2]),
                .chan_bad_q  (chan_bad[gi])
            );

            a_low_level: assert property (
                @(posedge pclk) disable iff (!presetn)
                (sense[gi] == SENSE_LOW && !route[gi] && level[gi] != LEVEL_OFF
                 && !flt_q[gi]) |=> irq_req[gi])
                else $error("low level did not request");

            a_high_level: assert property (
                @(posedge pclk) disable iff (!presetn)
                (sense[gi] == SENSE_HIGH && !route[gi] && level[gi] != LEVEL_OFF)
                |=> (irq_req[gi] == $past(flt_q[gi])))
                else $error("high level request mismatch");

            a_rise_edge: assert property (
                @(posedge pclk) disable iff (!presetn)
                (sense[gi] == SENSE_RISE && !route[gi] && level[gi] != LEVEL_OFF
                 && $stable(cfg_q) && $rose(flt_q[gi])) |=> irq_req[gi] ##1 !irq_req[gi]
                 || !$stable(flt_q[gi]))
                else $error("rising edge not one pulse");

            a_fall_edge: assert property (
                @(posedge pclk) disable iff (!presetn)
                (sense[gi] == SENSE_FALL && $stable(flt_q[gi])) |=> !irq_req[gi]
                 && !xfer_req[gi])
                else $error("falling edge request without edge");

            a_route_xfer: assert property (
                @(posedge pclk) disable iff (!presetn)
                route[gi] |=> !irq_req[gi])
                else $error("routed source reached processor");

            a_prio_off: assert property (
                @(posedge pclk) disable iff (!presetn)
                (level[gi] == LEVEL_OFF && !route[gi]) |=> !irq_req[gi] && !xfer_req[gi])
                else $error("disabled source requested");

            a_prio_value: assert property (
                @(posedge pclk) disable iff (!presetn)
                irq_req[gi] |-> irq_prio[gi*3 +: 3] == $past(level[gi])
                 && $past(level[gi]) != LEVEL_OFF)
                else $error("priority does not match level field");

            a_chan_invalid: assert property (
                @(posedge pclk) disable iff (!presetn)
                (route[gi] && level[gi][2]) |=> !xfer_req[gi] && chan_bad[gi])
                else $error("invalid channel started transfer");

            a_chan_value: assert property (
                @(posedge pclk) disable iff (!presetn)
                xfer_req[gi] |-> xfer_chan[gi*2 +: 2] == $past(level[gi][1:0])
                 && $past(route[gi]))
                else $error("transfer channel mismatch");

            c_xfer_start: cover property (
                @(posedge pclk) disable iff (!presetn)
                xfer_req[gi]);

            c_edge_irq: cover property (
                @(posedge pclk) disable iff (!presetn)
                sense[gi] == SENSE_RISE && irq_req[gi]);
        end
    endgenerate

    a_apb_answer: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("apb answer not one cycle");

    a_cfg_reserved: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg_q & ~CFG_WR_MASK) == 32'h0000_0000)
        else $error("unused config bits set");

    a_unmapped_err: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready && paddr != CFG_ADDR && paddr != STAT_ADDR)
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    c_cfg_write: cover property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && paddr == CFG_ADDR);

endmodule // irqcfg_top

// >>> shared/irqcfg_pkg.sv
// constants for the interrupt slot 8..11 configuration block
// assumes an APB3 master on pclk and two external request pins
// Operation
// - sources 10/11 sense code 00 low level, 01 high, 10 falling, 11 rising
// - routing flag 1 sends request to transfer controller, 0 to processor
// - with routing 0, level 000 disables, 001..111 give priority 1..7
// - with routing 1, level 000..011 picks channel 0..3; 1xx invalid
package irqcfg_pkg;

    localparam logic [31:0] CFG_ADDR    = 32'hffff_e008;
    localparam logic [31:0] STAT_ADDR   = 32'hffff_e0f0;
    localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
    localparam logic [31:0] CFG_WR_MASK = 32'h3f3f_3f3f;

    // one byte per slot, slots 8..11 in bytes 0..3
    localparam int SLOT_W      = 8;
    localparam int EXT_FIRST   = 2;
    localparam int NUM_EXT     = 2;
    localparam int LEVEL_LSB   = 0;
    localparam int ROUTE_BIT   = 3;
    localparam int SENSE_LSB   = 4;

    // status register fields
    localparam int STAT_PIN_LSB = 0;
    localparam int STAT_BAD_LSB = 2;

    localparam logic [1:0] SENSE_LOW  = 2'h0;
    localparam logic [1:0] SENSE_HIGH = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;

    localparam logic [2:0] LEVEL_OFF  = 3'h0;

endpackage

// >>> sim/irqcfg_pins.sv
// behavioural model of the two external request pins
// assumes the bench calls drive, which moves the pins just after a clock edge
`timescale 1ns/10ps
module irqcfg_pins
(
    input  wire logic pclk,
    output logic      pin_a,
    output logic      pin_b
);
    initial
    begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end

    task automatic drive(input logic a, input logic b);
        @(posedge pclk);
        pin_a <= a;
        pin_b <= b;
    endtask
endmodule // irqcfg_pins

// >>> sim/tb_top.sv
// self-checking bench for the slot 8..11 configuration block
// assumes the pin model irqcfg_pins and the design top irqcfg_top
`timescale 1ns/10ps
module tb_top
    import irqcfg_pkg::*;
;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] paddr   = 32'h0000_0000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin_a;
    logic        pin_b;
    logic [1:0]  irq_req;
    logic [5:0]  irq_prio;
    logic [1:0]  xfer_req;
    logic [3:0]  xfer_chan;
    logic [31:0] rd;
    logic        err;
    logic [31:0] cnt_a;
    logic [31:0] cnt_b;
    logic [31:0] cnt_x;
    logic [31:0] cnt_y;
    logic [1:0]  sv;
    int          errors      = 0;
    int          checks_done = 0;

    initial
    begin
        forever #5 pclk = ~pclk;
    end

    irqcfg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b), .irq_req(irq_req),
        .irq_prio(irq_prio), .xfer_req(xfer_req), .xfer_chan(xfer_chan));
    irqcfg_pins u_pins (.pclk(pclk), .pin_a(pin_a), .pin_b(pin_b));

    task automatic complete_run();
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        chk(pready, 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // count request cycles after a pin change
    task automatic watch(input int n);
        cnt_a = 0;
        cnt_b = 0;
        cnt_x = 0;
        cnt_y = 0;
        repeat (n)
        begin
            @(posedge pclk);
            cnt_a += irq_req[0];
            cnt_b += irq_req[1];
            cnt_x += xfer_req[1];
            cnt_y += xfer_req[0];
        end
    endtask

    initial
    begin
        repeat (8) @(posedge pclk);
        chk({18'h0_0000, irq_req, irq_prio, xfer_req, xfer_chan}, 32'h0000_0000);
        presetn <= 1'b1;
        apb(1'b0, CFG_ADDR, 32'h0000_0000);
        chk(rd, CFG_RESET);
        chk(err, 1'b0);
        apb(1'b1, CFG_ADDR, 32'hf7f7_0000);
        apb(1'b0, CFG_ADDR, 32'h0000_0000);
        chk(rd, 32'hf7f7_0000 & CFG_WR_MASK);
        apb(1'b0, 32'hffff_e100, 32'h0000_0000);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
        for (int s = 0; s < 4; s++)
        begin
            sv = s[1:0];
            u_pins.drive(~sv[0], ~sv[0]);
            apb(1'b1, CFG_ADDR, {2'b00, sv, 4'h0, 2'b00, sv, 4'h0, 16'h0000});
            repeat (10) @(posedge pclk);
            apb(1'b1, CFG_ADDR, {2'b00, sv, 4'h0, 2'b00, sv, 4'h5, 16'h0000});
            repeat (10) @(posedge pclk);
            u_pins.drive(sv[0], sv[0]);
            watch(20);
            chk(cnt_b, 32'h0000_0000);
            if (sv[1])
                chk(cnt_a, 32'h0000_0001);
            else
                chk(irq_req[0], 1'b1);
            chk(irq_prio[2:0], 3'h5);
            chk(xfer_req, 2'b00);
        end
        apb(1'b1, CFG_ADDR, 32'h1000_0000);
        repeat (10) @(posedge pclk);
        apb(1'b1, CFG_ADDR, 32'h1300_0000);
        repeat (10) @(posedge pclk);
        chk(irq_req, 2'b10);
        chk(irq_prio[5:3], 3'h3);
        u_pins.drive(1'b0, 1'b0);
        apb(1'b1, CFG_ADDR, 32'h3030_0000);
        repeat (10) @(posedge pclk);
        apb(1'b1, CFG_ADDR, 32'h3a39_0000);
        repeat (10) @(posedge pclk);
        u_pins.drive(1'b1, 1'b1);
        watch(20);
        chk(cnt_x, 32'h0000_0001);
        chk(cnt_y, 32'h0000_0001);
        chk(cnt_a + cnt_b, 32'h0000_0000);
        chk(xfer_chan, 4'h9);
        apb(1'b1, CFG_ADDR, 32'h3d00_0000);
        u_pins.drive(1'b1, 1'b0);
        repeat (10) @(posedge pclk);
        u_pins.drive(1'b1, 1'b1);
        watch(20);
        chk(cnt_x, 32'h0000_0000);
        apb(1'b0, STAT_ADDR, 32'h0000_0000);
        chk(rd, 32'h0000_000b);
        complete_run();
    end

    initial
    begin
        #200000;
        errors++;
        complete_run();
    end
endmodule // tb_top
